/* File: logic/nvmac_top.sv */
// core-side register port and sequencer for the non-volatile array
// assumes strobes are synchronous to core_clk; slow_tick is a raw pin
// from the asynchronous slow timer and is synchronised here
`timescale 1ns/1ps
module nvmac_top #(
    parameter int unsigned write_ticks = nvmac_pkg::nvmac_write_ticks
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic index_wr, // write strobe, index register
    input wire logic data_wr, // write strobe, data register
    input wire logic ctrl_wr, // write strobe, control register
    input wire logic bank_wr, // write strobe, bank selector
    input wire logic [7:0] wdata, // write byte for any strobe
    input wire logic slow_tick, // slow timer clock, asynchronous
    input wire logic nvm_irq_enable, // interrupt enable bit
    input wire logic global_irq_enable, // global interrupt enable
    input wire logic stack_full, // call stack full
    input wire logic irq_service, // core services the vector
    output logic [7:0] nvm_index_register, // index readback
    output logic [7:0] nvm_data_register, // data readback
    output logic [7:0] nvm_control_register, // control readback
    output logic [2:0] bank_selector, // bank selector readback
    output logic nvm_irq_flag, // write-end request flag
    output logic irq_request, // vector jump request
    output logic busy // operation in progress
);
    // ==========================================================
    // elaboration check: the tick counter is sixteen bits wide, and a
    // zero count would wrap to 16'hffff and stretch the write to 65536 ticks
    if (write_ticks < 1 || write_ticks > 65535) begin : g_bad_ticks
        $error("write_ticks out of range");
    end

    // ==========================================================
    // state
    // sequencer: idle, timed read or timed write
    nvmac_pkg::nvmac_state_type state, next_state;
    // index only moves while the sequencer is idle; data also takes the array byte as a read ends
    logic [4:0] index, next_index; // byte address
    logic [7:0] data, next_data; // data register contents
    // control register: permits are plain bits, triggers self-clear
    logic program_permit, next_program_permit; // write permit
    logic wr, next_wr; // write trigger
    logic fetch_permit, next_fetch_permit; // read permit
    logic rd, next_rd; // read trigger
    // bank selector and write-end request flag
    logic [2:0] bank, next_bank; // bank selector
    logic flag, next_flag; // request flag
    // one counter serves the read delay and the slow tick count
    logic [15:0] cnt, next_cnt; // tick or cycle count
    // the slow timer has no phase relation to core_clk
    logic tick_s1, tick_s2, tick_s3; // slow tick synchroniser
    logic tick_rise; // one-cycle pulse per slow tick
    // array side
    logic arr_we; // program strobe, high for one cycle
    logic [7:0] arr_q; // registered array byte

    nvmac_array #(
        .addr_w(nvmac_pkg::nvmac_addr_w),
        .data_w(nvmac_pkg::nvmac_data_w)
    ) u_array (
        .core_clk(core_clk),
        .wr_en(arr_we),
        .addr(index),
        .wr_data(data),
        .rd_data(arr_q)
    );

    // two flops before use, third only to find the edge
    // these flops carry no reset: they only follow the pin
    always_ff @(posedge core_clk) begin
        tick_s1 <= slow_tick;
        tick_s2 <= tick_s1;
        tick_s3 <= tick_s2;
    end
    assign tick_rise = tick_s2 & ~tick_s3;

    // ==========================================================
    // next-state logic
    always_comb begin
        // hold everything unless a branch below moves it
        next_state = state;
        next_index = index;
        next_data = data;
        next_program_permit = program_permit;
        next_wr = wr;
        next_fetch_permit = fetch_permit;
        next_rd = rd;
        next_bank = bank;
        next_flag = flag;
        next_cnt = cnt;
        arr_we = 1'b0;
        // core service clears the flag; a same-cycle write end wins below
        if (irq_service) begin
            next_flag = 1'b0;
        end
        // the bank selector is writable even while busy
        if (bank_wr) begin
            next_bank = wdata[2:0];
        end
        case (state)
            nvmac_pkg::nvmac_idle: begin
                // only five index bits are kept, the top three read zero
                if (index_wr) begin
                    next_index = wdata[4:0];
                end
                // data register: software byte in, read result back
                if (data_wr) begin
                    next_data = wdata;
                end
                if (ctrl_wr) begin
                    // permits follow the written byte directly
                    next_program_permit =
                        wdata[nvmac_pkg::nvmac_bit_program_permit];
                    next_fetch_permit =
                        wdata[nvmac_pkg::nvmac_bit_fetch_permit];
                    // trigger needs the permit already held, so a single
                    // byte that sets permit and trigger together only sets
                    // the permit; the write trigger wins if both are set
                    if (wdata[nvmac_pkg::nvmac_bit_wr]
                            && program_permit) begin
                        next_wr = 1'b1;
                        next_cnt = 16'h0000;
                        next_state = nvmac_pkg::nvmac_writing;
                    end else if (wdata[nvmac_pkg::nvmac_bit_rd]
                            && fetch_permit) begin
                        next_rd = 1'b1;
                        next_cnt = 16'h0000;
                        next_state = nvmac_pkg::nvmac_reading;
                    end
                end
            end
            nvmac_pkg::nvmac_reading: begin
                // registered array output settles after one cycle; the
                // index cannot move while busy, so the byte is the one
                // addressed when the trigger was taken
                next_cnt = cnt + 16'h0001;
                if (cnt == 16'(nvmac_pkg::nvmac_read_cycles - 1)) begin
                    next_data = arr_q;
                    next_rd = 1'b0;
                    next_state = nvmac_pkg::nvmac_idle;
                end
            end
            nvmac_pkg::nvmac_writing: begin
                // control writes ignored while programming is timed;
                // software must wait for the trigger to clear anyway
                // slow ticks are counted only once synchronised, so the
                // duration is set by the slow timer, not by core_clk
                if (tick_rise) begin
                    next_cnt = cnt + 16'h0001;
                end
                if (tick_rise && cnt == 16'(write_ticks - 1)) begin
                    // program the array at the very end, then release
                    arr_we = 1'b1;
                    next_wr = 1'b0;
                    next_state = nvmac_pkg::nvmac_idle;
                    // this set overrides a service in the same cycle
                    if (nvm_irq_enable) begin
                        next_flag = 1'b1;
                    end
                end
            end
            // unreachable encoding: fall back to idle
            default: begin
                next_state = nvmac_pkg::nvmac_idle;
            end
        endcase
    end

    // ==========================================================
    // registers
    // synchronous reset; the array contents are deliberately not reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= nvmac_pkg::nvmac_idle;
            index <= nvmac_pkg::nvmac_reg_reset[4:0];
            data <= nvmac_pkg::nvmac_reg_reset;
            program_permit <= 1'b0;
            wr <= 1'b0;
            fetch_permit <= 1'b0;
            rd <= 1'b0;
            bank <= nvmac_pkg::nvmac_bank_reset;
            flag <= 1'b0;
            cnt <= 16'h0000;
        end else begin
            state <= next_state;
            index <= next_index;
            data <= next_data;
            program_permit <= next_program_permit;
            wr <= next_wr;
            fetch_permit <= next_fetch_permit;
            rd <= next_rd;
            bank <= next_bank;
            flag <= next_flag;
            cnt <= next_cnt;
        end
    end

    // registered outputs, built from next values to stay aligned
    // a readback shows the new value one edge after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nvm_index_register <= nvmac_pkg::nvmac_reg_reset;
            nvm_data_register <= nvmac_pkg::nvmac_reg_reset;
            nvm_control_register <= nvmac_pkg::nvmac_reg_reset;
            bank_selector <= nvmac_pkg::nvmac_bank_reset;
            nvm_irq_flag <= 1'b0;
            irq_request <= 1'b0;
            busy <= 1'b0;
        end else begin
            nvm_index_register <= {3'h0, next_index};
            nvm_data_register <= next_data;
            // unimplemented upper bits always read as zero
            nvm_control_register <= {4'h0, next_program_permit, next_wr,
                                     next_fetch_permit, next_rd};
            bank_selector <= next_bank;
            nvm_irq_flag <= next_flag;
            // the request also needs both enables and room on the stack
            irq_request <= next_flag & global_irq_enable
                           & nvm_irq_enable & ~stack_full;
            busy <= (next_state != nvmac_pkg::nvmac_idle);
        end
    end
endmodule : nvmac_top

/* File: logic/nvmac_pkg.sv */
// constants for the byte-wide non-volatile access controller
// assumes a core-side register port with per-register write strobes and registered readbacks
// Behaviour
// - index register holds five bits, upper zero
// - read result stays until next operation
// - program permit bit three gates writes
// - write trigger bit two self-clears after write
// - write trigger ignored without prior permit
// - fetch permit bit one gates reads
// - read trigger bit zero self-clears, data valid
// - read trigger ignored without prior permit
// - write timed by asynchronous slow timer
// - reset clears permit, control, index, data
// - write end raises flag when enabled
// - enabled pending flag requests vector, service clears
// - bank selector resets to zero
package nvmac_pkg;
    // ==========================================================
    // register layout
    localparam int unsigned nvmac_addr_w = 5;
    localparam int unsigned nvmac_data_w = 8;
    localparam int unsigned nvmac_depth = 32;
    localparam logic [7:0] nvmac_reg_reset = 8'h00;
    localparam int unsigned nvmac_bit_rd = 0;
    localparam int unsigned nvmac_bit_fetch_permit = 1;
    localparam int unsigned nvmac_bit_wr = 2;
    localparam int unsigned nvmac_bit_program_permit = 3;
    localparam logic [2:0] nvmac_bank_reset = 3'h0;
    localparam logic [7:0] nvmac_ctrl_loc = 8'h40;
    localparam logic [2:0] nvmac_ctrl_bank = 3'h1;
    // ==========================================================
    // timing
    localparam int unsigned nvmac_write_ticks = 64;  // slow-clock ticks
    localparam int unsigned nvmac_read_cycles = 2;
    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {
        nvmac_idle,
        nvmac_reading,
        nvmac_writing
    } nvmac_state_type;
endpackage : nvmac_pkg

/* File: logic/nvmac_array.sv */
// storage array of the non-volatile controller, one byte per word
// assumes one access per cycle; read data is registered
`timescale 1ns/1ps
module nvmac_array #(
    parameter int unsigned addr_w = 5,
    parameter int unsigned data_w = 8
) (
    input wire logic core_clk, // system clock
    input wire logic wr_en, // program strobe
    input wire logic [addr_w-1:0] addr, // byte address
    input wire logic [data_w-1:0] wr_data, // byte to store
    output logic [data_w-1:0] rd_data // registered read byte
);
    // ==========================================================
    // storage: contents survive reset, as a non-volatile array should
    logic [data_w-1:0] cells [0:(1<<addr_w)-1];

    // write port and registered read port
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            cells[addr] <= wr_data;
        end
        rd_data <= cells[addr];
    end
endmodule : nvmac_array

/* File: bench/nvmac_top_props.sv */
// assertions on the ports of the non-volatile access controller
// assumes it is bound to nvmac_top from the bench top file
`timescale 1ns/1ps
module nvmac_top_props #(
    parameter int unsigned write_ticks = 2
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic data_wr, // data strobe
    input wire logic nvm_irq_enable, // interrupt enable
    input wire logic global_irq_enable, // global enable
    input wire logic stack_full, // stack full
    input wire logic [7:0] nvm_index_register, // index readback
    input wire logic [7:0] nvm_data_register, // data readback
    input wire logic [7:0] nvm_control_register, // control readback
    input wire logic nvm_irq_flag, // request flag
    input wire logic irq_request, // vector request
    input wire logic busy // operation in progress
);
    // ==========================================================
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_idx;
        nvm_index_register[7:5] == 3'h0;
    endproperty
    a_idx: assert property (p_idx) else $error("index top bits set");
    property p_wr_permit;
        $rose(nvm_control_register[2]) |-> $past(nvm_control_register[3]);
    endproperty
    a_wr_permit: assert property (p_wr_permit) else $error("write no permit");
    property p_rd_permit;
        $rose(nvm_control_register[0]) |-> $past(nvm_control_register[1]);
    endproperty
    a_rd_permit: assert property (p_rd_permit) else $error("read no permit");
    property p_rd_clear;
        $rose(nvm_control_register[0]) |=> busy ##1 !nvm_control_register[0];
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read trigger");
    // idle data must not drift: a hazard if the array output leaked through
    property p_data_hold;
        !busy && !data_wr |=> $stable(nvm_data_register);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved");
    property p_wr_busy;
        nvm_control_register[2] |-> busy;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write not busy");
    property p_flag_end;
        $fell(nvm_control_register[2]) && nvm_irq_enable |-> nvm_irq_flag;
    endproperty
    a_flag_end: assert property (p_flag_end) else $error("flag not set");
    property p_irq_req;
        (nvm_irq_flag && global_irq_enable && nvm_irq_enable && !stack_full)[*2]
            |-> irq_request;
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("no request");
endmodule : nvmac_top_props

/* File: bench/tb_nvmac_top.sv */
// self-checking bench for the non-volatile access controller
// assumes nvmac_top and its package are compiled first
`timescale 1ns/1ps
module tb_nvmac_top;
    logic core_clk, rst_n, slow_tick, ie, gie, sfull, svc; // stimulus
    logic [3:0] strb; // index, data, control, bank strobes
    logic [7:0] wdata, idx_q, dat_q, ctl_q; // write byte and readbacks
    logic [2:0] bank_q; // bank readback
    logic flag, req, busy; // status outputs
    int miscompares = 0;
    int checks_done = 0;
    // ==========================================================
    // clocks: slow timer free-runs, unrelated in phase to the core
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        slow_tick = 1'b0;
        forever #37 slow_tick = ~slow_tick;
    end
    // short write count keeps the run brief
    nvmac_top #(.write_ticks(2)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .index_wr(strb[0]), .data_wr(strb[1]), .ctrl_wr(strb[2]),
        .bank_wr(strb[3]), .wdata(wdata), .slow_tick(slow_tick),
        .nvm_irq_enable(ie), .global_irq_enable(gie), .stack_full(sfull),
        .irq_service(svc), .nvm_index_register(idx_q),
        .nvm_data_register(dat_q), .nvm_control_register(ctl_q),
        .bank_selector(bank_q), .nvm_irq_flag(flag), .irq_request(req),
        .busy(busy));
    // ==========================================================
    // access tasks
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task finish_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // strobe stays up so back-to-back calls land on consecutive edges
    task wreg(input int s, input logic [7:0] v);
        @(posedge core_clk);
        strb <= 4'h1 << s;
        wdata <= v;
    endtask : wreg
    task idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            strb <= 4'h0;
        end
        #1;
    endtask : idle
    // bounded poll on a self-clearing trigger bit
    task poll(input int b);
        int k;
        for (k = 0; k < 200 && ctl_q[b] !== 1'b0; k++) idle(1);
        if (k == 200) begin
            miscompares++;
            finish_test();
        end
    endtask : poll
    // global interrupts masked from permit until the write has begun
    task do_write(input logic [7:0] a, input logic [7:0] d);
        wreg(0, a);
        wreg(1, d);
        gie <= 1'b0;
        wreg(2, 8'h08);
        wreg(2, 8'h0c);
        idle(1);
        chk("busy", {7'h00, busy}, 8'h01);
        @(posedge core_clk);
        gie <= 1'b1;
        #1;
        poll(2);
        chk("control", ctl_q, 8'h08);
    endtask : do_write
    task do_read(input logic [7:0] a);
        wreg(0, a);
        wreg(2, 8'h02);
        wreg(2, 8'h03);
        idle(1);
        poll(0);
        chk("control", ctl_q, 8'h02);
    endtask : do_read
    // ==========================================================
    // main sequence
    initial begin
        strb = 4'h0;
        wdata = 8'h00;
        {ie, gie, sfull, svc, rst_n} = 5'h18;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk("index", idx_q, 8'h00);
        chk("data", dat_q, 8'h00);
        chk("control", ctl_q, 8'h00);
        chk("bank", {5'h00, bank_q}, 8'h00);
        wreg(3, 8'h01);
        wreg(0, 8'hff);
        wreg(2, 8'h04);
        idle(2);
        chk("bank", {5'h00, bank_q}, 8'h01);
        chk("index", idx_q, 8'h1f);
        chk("control", ctl_q, 8'h00);
        do_write(8'h05, 8'ha5);
        chk("flag", {7'h00, flag}, 8'h01);
        idle(2);
        chk("request", {7'h00, req}, 8'h01);
        @(posedge core_clk);
        sfull <= 1'b1;
        idle(3);
        chk("request", {7'h00, req}, 8'h00);
        @(posedge core_clk);
        sfull <= 1'b0;
        svc <= 1'b1;
        @(posedge core_clk);
        svc <= 1'b0;
        idle(1);
        chk("flag", {7'h00, flag}, 8'h00);
        wreg(2, 8'h00);
        wreg(2, 8'h01);
        idle(2);
        chk("control", ctl_q, 8'h00);
        do_read(8'h05);
        idle(5);
        chk("data", dat_q, 8'ha5);
        // permit dropped: trigger alone must not program the array
        wreg(1, 8'h3c);
        wreg(2, 8'h00);
        wreg(2, 8'h04);
        idle(3);
        chk("control", ctl_q, 8'h00);
        do_read(8'h05);
        chk("data", dat_q, 8'ha5);
        do_write(8'h06, 8'h3c);
        do_read(8'h06);
        chk("data", dat_q, 8'h3c);
        do_read(8'h05);
        chk("data", dat_q, 8'ha5);
        finish_test();
    end
endmodule : tb_nvmac_top
bind nvmac_top nvmac_top_props #(.write_ticks(write_ticks)) i_props (
    .core_clk(core_clk), .rst_n(rst_n), .data_wr(data_wr),
    .nvm_irq_enable(nvm_irq_enable), .global_irq_enable(global_irq_enable),
    .stack_full(stack_full), .nvm_index_register(nvm_index_register),
    .nvm_data_register(nvm_data_register),
    .nvm_control_register(nvm_control_register),
    .nvm_irq_flag(nvm_irq_flag), .irq_request(irq_request), .busy(busy));
